// >>> vectored_interrupt_sequencer_tb_top.sv
/*
  Self-checking bench for the vectored interrupt sequencer.
  Assumes vis_pkg, vis_sequencer and the far-side model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module vectored_interrupt_sequencer_tb_top;
  import vis_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  wire logic pin, t1, t2, ad, done, multi, load;
  wire vis_op_t op;
  wire logic [PC_W-1:0] tgt;
  wire logic [CTX_W-1:0] ctx;
  logic [PC_W-1:0] pc, ret, exp_pc;
  logic [CTX_W-1:0] ctx_out, csave;
  logic taken, skip, restore, gie;
  logic [3:0] r, ef;
  logic [PC_W-1:0] vpc;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 75298;
  int n;

  always #5 CLOCK = ~CLOCK;

  vis_src_model u_m (.clk(CLOCK), .pin(pin), .t1_uf(t1), .t2_uf(t2), .ad_done(ad),
    .done(done), .op(op), .multi(multi), .load(load), .target(tgt), .ctx(ctx));

  vis_sequencer u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_IRQ(pin), .TIMER_ONE_UNDERFLOW(t1), .TIMER_TWO_UNDERFLOW(t2),
    .CONVERSION_DONE(ad), .INSTR_DONE(done), .INSTR_OP(op), .INSTR_MULTI(multi),
    .PC_LOAD(load), .PC_TARGET(tgt), .CONTEXT_IN(ctx), .PROGRAM_COUNTER(pc),
    .RETURN_ADDRESS(ret), .CONTEXT_OUT(ctx_out), .IRQ_TAKEN(taken), .SKIP_NEXT(skip),
    .CONTEXT_RESTORE(restore), .GLOBAL_IRQ_ENABLE(gie));

  // ----------------------------------------
  // Report and compare
  // ----------------------------------------
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Highest pending source decides the vector
  function automatic logic [PC_W-1:0] exp_vector(input logic [3:0] pend);
    if (pend[SRC_PIN]) return PC_W'(VEC_PIN);
    if (pend[SRC_T1]) return PC_W'(VEC_T1);
    if (pend[SRC_T2]) return PC_W'(VEC_T2);
    return PC_W'(VEC_AD);
  endfunction

  // ----------------------------------------
  // Bus and instruction helpers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge CLOCK);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLOCK);
    penable <= 1'b1;
    do begin
      @(posedge CLOCK);
      t++;
    end while (pready !== 1'b1 && t < 10);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: bus timeout", $time);
      complete_run();
    end
  endtask

  task automatic ex(input vis_op_t o, input logic l, input logic [PC_W-1:0] t);
    u_m.exec(o, l, t);
    #1;
  endtask

  // Bounded wait; a take that never comes ends the run
  task automatic wait_take(output int cnt);
    cnt = 0;
    do begin
      @(posedge CLOCK);
      #1;
      cnt++;
    end while (taken !== 1'b1 && cnt < 8);
    if (cnt >= 8) begin
      num_errors++;
      $display("Error at %0t: no interrupt taken", $time);
      complete_run();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    exp_pc = '0;
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    apb(1'b0, OFS_CTRL1, 32'h0);
    chk(rd, 32'h0, "ctrl1 reset");
    apb(1'b0, OFS_STATUS, 32'h0);
    // Idle state code sits in the state field
    chk(rd, 32'h80, "status reset");
    apb(1'b0, 12'h014, 32'h0);
    chk(err, 32'h1, "unmapped");
    r = 4'($random(seed));
    apb(1'b1, OFS_CTRL1, {28'h0, r});
    apb(1'b0, OFS_CTRL1, 32'h0);
    chk(rd, {28'h0, r}, "ctrl1 readback");
    apb(1'b1, OFS_CTRL1, 32'h0);
    $display("Test registers done");
    u_m.event_pulse(1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[3:0], 32'h2, "flag while blocked");
    ex(OP_SKIP_T1, 1'b0, '0);
    exp_pc++;
    chk(skip, 32'h1, "skip taken");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[3:0], 32'h0, "skip clears flag");
    for (int s = 0; s < 4; s++) u_m.event_pulse(s);
    repeat (4) @(posedge CLOCK);
    apb(1'b1, OFS_CTRL1, 32'hD);
    ex(OP_SKIP_PIN, 1'b0, '0);
    exp_pc++;
    chk(skip, 32'h0, "skip is no-op");
    ex(OP_SKIP_T2, 1'b0, '0);
    exp_pc++;
    chk(skip, 32'h0, "timer two skip no-op");
    ex(OP_SKIP_AD, 1'b0, '0);
    exp_pc++;
    chk(skip, 32'h1, "converter skip");
    u_m.event_pulse(3);
    ex(OP_NONE, 1'b1, 12'h07F);
    ex(OP_NONE, 1'b0, '0);
    exp_pc = 12'h080;
    chk(pc, exp_pc, "page wrap");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[3:0], 32'hF, "all flags held");
    $display("Test flags and skip done");
    ef = 4'hF;
    for (int k = 0; k < 4; k++) begin
      u_m.set_far($unsigned($random(seed)) % 3, k == 1, 20'($random(seed)));
      if (k == 3) begin
        ex(OP_EI, 1'b0, '0);
        ex(OP_NONE, 1'b0, '0);
        exp_pc += 2;
        repeat (6) begin
          @(posedge CLOCK);
          #1;
          chk(taken, 32'h0, "converter blocked");
        end
        chk(gie, 32'h1, "gie set");
        ex(OP_DI, 1'b0, '0);
        exp_pc++;
        chk(gie, 32'h0, "gie cleared");
        apb(1'b1, OFS_CTRL2, 32'h4);
      end
      ex(OP_EI, 1'b0, '0);
      exp_pc++;
      chk(gie, 32'h0, "enable delayed");
      ex(OP_NONE, 1'b0, '0);
      exp_pc++;
      csave = ctx;
      chk(gie, 32'h1, "enable active");
      wait_take(n);
      chk(n, (k == 1) ? 32'h3 : 32'h2, "latency");
      vpc = exp_vector(ef);
      chk(pc, vpc, "vector");
      chk(ret, exp_pc, "return address");
      chk(gie, 32'h0, "gie off on take");
      chk(ctx_out, csave, "context saved");
      ef[k] = 1'b0;
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[3:0], ef, "others pending");
      u_m.set_far(u_m.gap, multi, ~csave);
      ex(OP_NONE, 1'b0, '0);
      chk(pc, vpc + 12'h001, "routine step");
      chk(ctx_out, csave, "context held");
      ex(OP_RTI, 1'b0, '0);
      chk(pc, exp_pc, "resume");
      chk(restore, 32'h1, "restore pulse");
      $display("Test source %0d done", k);
    end
    complete_run();
  end
endmodule
`default_nettype wire

// >>> vis_pin_edge.sv
/*
  Level-change detector for the external interrupt pin.
  Assumes the pin is asynchronous to CLOCK; two flops precede any logic.
*/
`timescale 1ns/10ps
`default_nettype none
module vis_pin_edge (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic pin,
  output logic change
);
  import vis_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pulse;
  } vis_edge_t;

  vis_edge_t st_reg;
  vis_edge_t st_next;

  // ----------------------------------------
  // Synchroniser and edge
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
    // Both edges count as a level change
    st_next.pulse = st_reg.s2 ^ st_reg.prev;
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign change = st_reg.pulse;

endmodule
`default_nettype wire

// >>> vis_pkg.sv
/*
  Shared constants and types for the vectored interrupt sequencer.
  Assumes a 100 MHz machine-cycle clock and a 32-bit APB register bus.
*/
`default_nettype none
package vis_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PC_W = 12;
  localparam int CTX_W = 20;
  localparam int NSRC = 4;
  localparam int CTRL_W = 4;
  localparam int ADDR_W = 12;
  localparam int PAGE_LSB = 7;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL1 = 12'h000;
  localparam logic [11:0] OFS_CTRL2 = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_CONTEXT = 12'h00C;
  localparam logic [11:0] OFS_PC = 12'h010;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // ----------------------------------------
  // Enable bit positions and source order
  // ----------------------------------------
  localparam int CTRL1_PIN_BIT = 0;
  localparam int CTRL1_T1_BIT = 2;
  localparam int CTRL1_T2_BIT = 3;
  localparam int CTRL2_AD_BIT = 2;
  localparam int SRC_PIN = 0;
  localparam int SRC_T1 = 1;
  localparam int SRC_T2 = 2;
  localparam int SRC_AD = 3;

  // ----------------------------------------
  // Vectors, all inside page 1
  // ----------------------------------------
  localparam logic [7:0] VEC_PIN = 8'h80;
  localparam logic [7:0] VEC_T1 = 8'h84;
  localparam logic [7:0] VEC_T2 = 8'h86;
  localparam logic [7:0] VEC_AD = 8'h8C;
  localparam logic [7:0] VEC_AREA_LO = 8'h80;
  localparam logic [7:0] VEC_AREA_HI = 8'hFF;

  // ----------------------------------------
  // Sequencer opcodes and states
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_EI = 3'h1,
    OP_DI = 3'h2,
    OP_RTI = 3'h3,
    OP_SKIP_PIN = 3'h4,
    OP_SKIP_T1 = 3'h5,
    OP_SKIP_T2 = 3'h6,
    OP_SKIP_AD = 3'h7
  } vis_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_EXTRA = 3'h4
  } vis_state_t;

endpackage
`default_nettype wire

// >>> vis_prio.sv
/*
  Fixed-priority grant and vector lookup for four interrupt sources.
  Assumes requests are already gated by enables; purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module vis_prio (
  input wire logic [vis_pkg::NSRC-1:0] req,
  output logic [vis_pkg::NSRC-1:0] grant,
  output logic [7:0] vector,
  output logic any
);
  import vis_pkg::*;

  // ----------------------------------------
  // Lowest index wins
  // ----------------------------------------
  always_comb begin
    grant = '0;
    vector = VEC_PIN;
    if (req[SRC_PIN]) begin
      grant[SRC_PIN] = 1'b1;
      vector = VEC_PIN;
    end else if (req[SRC_T1]) begin
      grant[SRC_T1] = 1'b1;
      vector = VEC_T1;
    end else if (req[SRC_T2]) begin
      grant[SRC_T2] = 1'b1;
      vector = VEC_T2;
    end else if (req[SRC_AD]) begin
      grant[SRC_AD] = 1'b1;
      vector = VEC_AD;
    end
    any = |req;
  end

endmodule
`default_nettype wire

// >>> vis_sequencer.sv
/*
  Vectored interrupt sequencer: request flags, enables, global enable,
  priority, vector load, return address and one-stage context save.
  Assumes an APB master on the same clock and an instruction sequencer
  that reports each completed instruction with a one-cycle INSTR_DONE.
*/
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Interrupt needs request flag, source enable bit and global enable all set.
// - Enable instruction sets the global enable; disable instruction clears it.
// - Taking any interrupt clears the global enable.
// - Enable bit one blocks skip test; zero blocks interrupt and lets skip test.
// - Enables: pin bit0, timer one bit2, timer two bit3 of first; converter bit2 second.
// - Request flag sets on its event even while the interrupt is blocked.
// - Flag clears only when its interrupt is taken or its skip skips.
// - Set flag holds, so a pending request fires once unblocked.
// - Priority order: pin, timer one, timer two, converter.
// - Events: pin level change, timer underflows, conversion done.
// - Vectors lie in page 1, the whole page 0x80 to 0xFF.
// - Taking an interrupt clears only the serviced source's flag.
// - Taking pushes return address and loads the vector into the counter.
// - Taking saves pointer, carry, skip and both accumulators in the save register.
// - Return instruction resumes at the pushed return address.
// - Enable instruction takes effect after one further instruction completes.
// - Counter is page field above in-page field; 127 wraps to next page.
// - Taken two cycles after conditions, three during a multi-cycle instruction.
// - Save register holds until return, then is restored.
module vis_sequencer #(
  parameter int PC_WIDTH = vis_pkg::PC_W,
  parameter int CTX_WIDTH = vis_pkg::CTX_W
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [vis_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PIN_IRQ,
  input wire logic TIMER_ONE_UNDERFLOW,
  input wire logic TIMER_TWO_UNDERFLOW,
  input wire logic CONVERSION_DONE,
  input wire logic INSTR_DONE,
  input wire vis_pkg::vis_op_t INSTR_OP,
  input wire logic INSTR_MULTI,
  input wire logic PC_LOAD,
  input wire logic [PC_WIDTH-1:0] PC_TARGET,
  input wire logic [CTX_WIDTH-1:0] CONTEXT_IN,
  output logic [PC_WIDTH-1:0] PROGRAM_COUNTER,
  output logic [PC_WIDTH-1:0] RETURN_ADDRESS,
  output logic [CTX_WIDTH-1:0] CONTEXT_OUT,
  output logic IRQ_TAKEN,
  output logic SKIP_NEXT,
  output logic CONTEXT_RESTORE,
  output logic GLOBAL_IRQ_ENABLE
);
  import vis_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl1;
    logic [CTRL_W-1:0] ctrl2;
    logic [NSRC-1:0] flags;
    logic gie;
    logic ei_arm;
    vis_state_t state;
    logic multi;
    logic [PC_WIDTH-1:0] pc;
    logic [PC_WIDTH-1:0] ret;
    logic [CTX_WIDTH-1:0] ctx;
    logic taken;
    logic skip;
    logic restore;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } vis_core_t;

  vis_core_t st_reg;
  vis_core_t st_next;

  logic pin_change;
  logic [NSRC-1:0] ev;
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] grant;
  logic [7:0] vector;
  logic any;
  logic do_take;
  logic [PC_WIDTH-1:0] seq_pc;
  logic [NSRC-1:0] clr;
  logic mapped;
  logic wr_acc;

  // ----------------------------------------
  // Sources and priority
  // ----------------------------------------
  vis_pin_edge u_pin (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .pin(PIN_IRQ),
    .change(pin_change)
  );

  assign ev = {CONVERSION_DONE, TIMER_TWO_UNDERFLOW, TIMER_ONE_UNDERFLOW, pin_change};
  assign en = {st_reg.ctrl2[CTRL2_AD_BIT], st_reg.ctrl1[CTRL1_T2_BIT],
               st_reg.ctrl1[CTRL1_T1_BIT], st_reg.ctrl1[CTRL1_PIN_BIT]};
  assign req = st_reg.flags & en & {NSRC{st_reg.gie}};

  vis_prio u_prio (
    .req(req),
    .grant(grant),
    .vector(vector),
    .any(any)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign mapped = (PADDR == OFS_CTRL1) || (PADDR == OFS_CTRL2) || (PADDR == OFS_STATUS) ||
                  (PADDR == OFS_CONTEXT) || (PADDR == OFS_PC);
  assign wr_acc = PSEL && PENABLE && PWRITE && st_reg.pready && mapped;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.taken = 1'b0;
    st_next.skip = 1'b0;
    st_next.restore = 1'b0;
    clr = '0;
    do_take = 1'b0;

    // Normal program counter flow; the binary carry walks 127 into the next page
    seq_pc = st_reg.pc;
    if (INSTR_DONE) begin
      if (PC_LOAD) begin
        seq_pc = PC_TARGET;
      end else begin
        seq_pc = st_reg.pc + PC_WIDTH'(1);
      end
    end
    st_next.pc = seq_pc;

    // Instruction effects
    if (INSTR_DONE) begin
      if (st_reg.ei_arm) begin
        st_next.gie = 1'b1;
        st_next.ei_arm = 1'b0;
      end
      case (INSTR_OP)
        OP_EI: begin
          st_next.ei_arm = 1'b1;
        end
        OP_DI: begin
          st_next.gie = 1'b0;
          st_next.ei_arm = 1'b0;
        end
        OP_RTI: begin
          st_next.pc = st_reg.ret;
          st_next.restore = 1'b1;
        end
        OP_SKIP_PIN, OP_SKIP_T1, OP_SKIP_T2, OP_SKIP_AD: begin
          // Skip test only acts while the source's interrupt is disabled
          if (!en[INSTR_OP[1:0]] && st_reg.flags[INSTR_OP[1:0]]) begin
            st_next.skip = 1'b1;
            clr[INSTR_OP[1:0]] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Take sequence: wait one or two cycles, then commit
    case (st_reg.state)
      ST_IDLE: begin
        if (any) begin
          st_next.state = ST_WAIT;
          st_next.multi = INSTR_MULTI;
        end
      end
      ST_WAIT: begin
        if (!any) begin
          st_next.state = ST_IDLE;
        end else if (st_reg.multi) begin
          st_next.state = ST_EXTRA;
        end else begin
          do_take = 1'b1;
          st_next.state = ST_IDLE;
        end
      end
      ST_EXTRA: begin
        do_take = any;
        st_next.state = ST_IDLE;
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase

    // Grant is re-evaluated at commit, so a late higher source still wins
    if (do_take) begin
      st_next.taken = 1'b1;
      st_next.gie = 1'b0;
      st_next.ei_arm = 1'b0;
      clr = clr | grant;
      st_next.ret = seq_pc;
      st_next.pc = PC_WIDTH'(vector);
      st_next.ctx = CONTEXT_IN;
      st_next.restore = 1'b0;
    end

    // An event in the clearing cycle wins over the clear
    st_next.flags = (st_reg.flags & ~clr) | ev;

    // APB: answer one cycle after setup, read data latched in setup
    st_next.pready = PSEL && !PENABLE;
    st_next.pslverr = PSEL && !PENABLE && !mapped;
    if (PSEL && !PENABLE && !PWRITE) begin
      st_next.prdata = '0;
      case (PADDR)
        OFS_CTRL1: st_next.prdata[CTRL_W-1:0] = st_reg.ctrl1;
        OFS_CTRL2: st_next.prdata[CTRL_W-1:0] = st_reg.ctrl2;
        OFS_STATUS: st_next.prdata[9:0] = {st_reg.state, st_reg.multi, st_reg.ei_arm,
                                            st_reg.gie, st_reg.flags};
        OFS_CONTEXT: st_next.prdata[CTX_WIDTH-1:0] = st_reg.ctx;
        OFS_PC: st_next.prdata[PC_WIDTH-1:0] = st_reg.pc;
        default: st_next.prdata = '0;
      endcase
    end
    if (wr_acc && PADDR == OFS_CTRL1) begin
      st_next.ctrl1 = PWDATA[CTRL_W-1:0];
    end
    if (wr_acc && PADDR == OFS_CTRL2) begin
      st_next.ctrl2 = PWDATA[CTRL_W-1:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
      st_reg.ctrl1 <= CTRL_RESET;
      st_reg.ctrl2 <= CTRL_RESET;
      st_reg.state <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign PROGRAM_COUNTER = st_reg.pc;
  assign RETURN_ADDRESS = st_reg.ret;
  assign CONTEXT_OUT = st_reg.ctx;
  assign IRQ_TAKEN = st_reg.taken;
  assign SKIP_NEXT = st_reg.skip;
  assign CONTEXT_RESTORE = st_reg.restore;
  assign GLOBAL_IRQ_ENABLE = st_reg.gie;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  a_take_needs_all: assert property (
    st_reg.taken |-> $past(st_reg.gie, 2) && ($past(st_reg.flags & en, 2) != '0))
    else $error("interrupt taken without all three conditions");

  a_di_clears_gie: assert property (
    INSTR_DONE && INSTR_OP == OP_DI |=> !st_reg.gie)
    else $error("disable instruction left global enable set");

  a_take_clears_gie: assert property (
    st_reg.taken |-> !st_reg.gie && !st_reg.ei_arm)
    else $error("global enable still set after take");

  a_skip_blocked: assert property (
    INSTR_DONE && INSTR_OP == OP_SKIP_T1 && st_reg.ctrl1[CTRL1_T1_BIT] |=> !st_reg.skip)
    else $error("skip acted while its interrupt was enabled");

  a_flag_sets: assert property (
    (ev != '0) |=> ((st_reg.flags & $past(ev)) == $past(ev)))
    else $error("event did not set its request flag");

  a_flag_clear_cause: assert property (
    (($past(st_reg.flags) & ~st_reg.flags) != '0) |-> st_reg.taken || st_reg.skip)
    else $error("request flag cleared without take or skip");

  a_one_cleared: assert property (
    st_reg.taken |-> $countones($past(st_reg.flags) & ~st_reg.flags) <= 1)
    else $error("take cleared more than one request flag");

  a_prio_order: assert property (
    (req != '0) |-> grant == (req & (~req + 4'h1)))
    else $error("grant not the highest priority pending source");

  a_vector_area: assert property (
    st_reg.taken |-> st_reg.pc[PC_WIDTH-1:8] == '0 && st_reg.pc[7:0] >= VEC_AREA_LO &&
                     st_reg.pc[7:0] <= VEC_AREA_HI)
    else $error("vector outside the interrupt area");

  a_take_short: assert property (
    st_reg.state == ST_IDLE && any && !INSTR_MULTI ##1 any |-> ##1 st_reg.taken)
    else $error("interrupt not taken two cycles after conditions");

  a_take_long: assert property (
    st_reg.state == ST_IDLE && any && INSTR_MULTI ##1 any ##1 any |-> ##1 st_reg.taken)
    else $error("interrupt not taken three cycles after conditions");

  a_ei_delayed: assert property (
    $rose(st_reg.gie) |-> $past(st_reg.ei_arm && INSTR_DONE))
    else $error("global enable rose without a completed following instruction");

  a_rti_resume: assert property (
    INSTR_DONE && INSTR_OP == OP_RTI && !do_take |=> st_reg.pc == $past(st_reg.ret) &&
                                                     st_reg.restore)
    else $error("return did not resume at the pushed address");

  a_page_wrap: assert property (
    INSTR_DONE && !PC_LOAD && INSTR_OP != OP_RTI && !do_take &&
    st_reg.pc[PAGE_LSB-1:0] == 7'h7F |=> st_reg.pc[PAGE_LSB-1:0] == 7'h00 &&
    st_reg.pc[PC_WIDTH-1:PAGE_LSB] == $past(st_reg.pc[PC_WIDTH-1:PAGE_LSB]) + 1'b1)
    else $error("counter did not wrap to the next page");

  a_ctx_saved: assert property (
    st_reg.taken |-> st_reg.ctx == $past(CONTEXT_IN))
    else $error("context not saved on take");

endmodule
`default_nettype wire

// >>> vis_src_model.sv
/*
  Far-side model: on-chip request sources and the instruction sequencer.
  Assumes the sequencer under test samples every input at CLOCK rising edges.
*/
`timescale 1ns/10ps
`default_nettype none
module vis_src_model (
  input wire logic clk,
  output var logic pin,
  output var logic t1_uf,
  output var logic t2_uf,
  output var logic ad_done,
  output var logic done,
  output var vis_pkg::vis_op_t op,
  output var logic multi,
  output var logic load,
  output var logic [vis_pkg::PC_W-1:0] target,
  output var logic [vis_pkg::CTX_W-1:0] ctx
);
  import vis_pkg::*;
  int gap;

  initial begin
    {pin, t1_uf, t2_uf, ad_done, done, multi, load} = '0;
    op = OP_NONE;
    target = '0;
    ctx = '0;
    gap = 0;
  end

  // ----------------------------------------
  // Instruction completion
  // ----------------------------------------
  // Idle gap lets the sequencer answer slowly as well as promptly
  task automatic exec(input vis_op_t o, input logic l, input logic [PC_W-1:0] t);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    done <= 1'b1;
    op <= o;
    load <= l;
    target <= t;
    @(posedge clk);
    done <= 1'b0;
    op <= OP_NONE;
    load <= 1'b0;
  endtask

  // ----------------------------------------
  // Source events
  // ----------------------------------------
  // Pin keeps its new level, so the change lasts well past the sync stages
  task automatic event_pulse(input int s);
    @(posedge clk);
    case (s)
      0: pin <= ~pin;
      1: t1_uf <= 1'b1;
      2: t2_uf <= 1'b1;
      default: ad_done <= 1'b1;
    endcase
    @(posedge clk);
    t1_uf <= 1'b0;
    t2_uf <= 1'b0;
    ad_done <= 1'b0;
  endtask

  // ----------------------------------------
  // Mode and live context
  // ----------------------------------------
  // Changed only at an edge, so the sequencer never sees a half-updated context
  task automatic set_far(input int g, input logic m, input logic [CTX_W-1:0] c);
    @(posedge clk);
    gap = g;
    multi <= m;
    ctx <= c;
  endtask
endmodule
`default_nettype wire
